// [logic/dmc_pkg.sv]
/*
 * Constants, register indices and carrier types of the four-channel
 * transfer controller. Assumes a single clock and an AXI4-Lite host.
 */
package dmc_pkg;
	localparam int NCH = 4;
	localparam int AW  = 24;
	localparam int DW  = 16;
	localparam int CW  = 16;
	localparam int XW  = 14;

	// Register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_IC0 = 12'h068;
	localparam logic [11:0] IDX_IC1 = 12'h088;
	localparam logic [11:0] IDX_IC2 = 12'h06A;
	localparam logic [11:0] IDX_IC3 = 12'h08A;
	localparam logic [11:0] IDX_SL0 = 12'h378;
	localparam logic [11:0] IDX_CHB = 12'h400;

	localparam logic [2:0] K_IC   = 3'h0;
	localparam logic [2:0] K_SL   = 3'h1;
	localparam logic [2:0] K_MODE = 3'h2;
	localparam logic [2:0] K_FIX  = 3'h3;
	localparam logic [2:0] K_MEM  = 3'h4;
	localparam logic [2:0] K_MRL  = 3'h5;
	localparam logic [2:0] K_CNT  = 3'h6;
	localparam logic [2:0] K_CRL  = 3'h7;
	localparam logic [2:0] K_OFS  = 3'h2;

	localparam int SL_SW   = 5;
	localparam int IC_FLAG = 3;
	localparam int MD_DIR  = 0;
	localparam int MD_RPT  = 1;
	localparam int MD_EN   = 2;

	localparam logic [AW-1:0] ADDR_STEP = 24'h000001;
	localparam logic [CW-1:0] CNT_ONE   = 16'h0001;
	localparam logic [1:0]    RESP_OK   = 2'h0;
	localparam logic [1:0]    RESP_ERR  = 2'h2;

	typedef enum {ST_IDLE, ST_RD, ST_WR} dmc_state_t;

	typedef struct packed {
		logic [2:0]    mode;
		logic [AW-1:0] fix;
		logic [AW-1:0] mem;
		logic [AW-1:0] mrl;
		logic [CW-1:0] cnt;
		logic [CW-1:0] crl;
		logic [4:0]    src;
		logic          pend;
		logic [2:0]    lvl;
		logic          flag;
	} dmc_chan_t;

	typedef struct packed {
		logic          req;
		logic          we;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} dmc_mem_t;

	typedef struct packed {
		logic       hit;
		logic [2:0] kind;
		logic [1:0] ch;
	} dmc_dec_t;
endpackage

// [logic/dmc_top.sv]
/*
 * Four-channel transfer controller with an AXI4-Lite register slave and
 * a request/acknowledge memory master port.
 * Assumes peripheral request lines on the same clock and a memory that
 * answers each held request with a one-cycle acknowledge.
 */
////////////////////////////////////////////////////////////////////////////
module dmc_top (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic [dmc_pkg::XW-1:0]  s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [dmc_pkg::XW-1:0]  s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic [31:0]             periph_req,
	output dmc_pkg::dmc_mem_t            mem_cmd,
	input  wire logic                    mem_ack,
	input  wire logic [dmc_pkg::DW-1:0]  mem_rdata,
	output logic [dmc_pkg::NCH-1:0]      irq_req
);

	////////////////////////////////////////////////////////////////////////
	function automatic dmc_pkg::dmc_dec_t dec(input logic [13:0] a);
		dmc_pkg::dmc_dec_t d;
		logic [11:0]       ix;
		d  = '0;
		ix = a[13:2];
		if (ix == dmc_pkg::IDX_IC0)
			d = '{1'b1, dmc_pkg::K_IC, 2'h0};
		else if (ix == dmc_pkg::IDX_IC1)
			d = '{1'b1, dmc_pkg::K_IC, 2'h1};
		else if (ix == dmc_pkg::IDX_IC2)
			d = '{1'b1, dmc_pkg::K_IC, 2'h2};
		else if (ix == dmc_pkg::IDX_IC3)
			d = '{1'b1, dmc_pkg::K_IC, 2'h3};
		else if (ix[11:2] == dmc_pkg::IDX_SL0[11:2])
			d = '{1'b1, dmc_pkg::K_SL, ix[1:0]};
		else if (ix[11:5] == dmc_pkg::IDX_CHB[11:5] && ix[2:0] < 3'h6)
			d = '{1'b1, 3'(ix[2:0] + dmc_pkg::K_OFS), ix[4:3]};
		return d;
	endfunction

	function automatic logic [31:0] rd_reg(input dmc_pkg::dmc_dec_t d,
		input dmc_pkg::dmc_chan_t c);
		logic [31:0] v;
		v = 32'h0;
		case (d.kind)
			dmc_pkg::K_IC:   v = {28'h0, c.flag, c.lvl};
			dmc_pkg::K_SL:   v = {24'h0, c.pend, 2'h0, c.src};
			dmc_pkg::K_MODE: v = {29'h0, c.mode};
			dmc_pkg::K_FIX:  v = {8'h0, c.fix};
			dmc_pkg::K_MEM:  v = {8'h0, c.mem};
			dmc_pkg::K_MRL:  v = {8'h0, c.mrl};
			dmc_pkg::K_CNT:  v = {16'h0, c.cnt};
			default:         v = {16'h0, c.crl};
		endcase
		return v;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	////////////////////////////////////////////////////////////////////////
	dmc_pkg::dmc_chan_t   ch_ff   [dmc_pkg::NCH];
	dmc_pkg::dmc_chan_t   nxt_ch  [dmc_pkg::NCH];
	dmc_pkg::dmc_chan_t   cur;
	dmc_pkg::dmc_state_t  st_ff,  nxt_st;
	dmc_pkg::dmc_mem_t    mem_ff, nxt_mem;
	dmc_pkg::dmc_dec_t    dw, dr;
	logic [1:0]           cur_ff, nxt_cur;
	logic [31:0]          prev_ff, nxt_prev;
	logic                 awh_ff, nxt_awh, wh_ff, nxt_wh;
	logic [13:0]          awa_ff, nxt_awa;
	logic [31:0]          wd_ff,  nxt_wd;
	logic [3:0]           ws_ff,  nxt_ws;
	logic                 awr_ff, nxt_awr, wr_ff, nxt_wr, arr_ff, nxt_arr;
	logic                 bv_ff,  nxt_bv,  rv_ff, nxt_rv;
	logic [1:0]           br_ff,  nxt_br,  rr_ff, nxt_rr;
	logic [31:0]          rd_ff,  nxt_rd;
	logic [31:0]          wv;
	logic [dmc_pkg::NCH-1:0] swreq;
	logic                 found;

	assign cur           = ch_ff[cur_ff];
	assign mem_cmd       = mem_ff;
	assign s_axi_awready = awr_ff;
	assign s_axi_wready  = wr_ff;
	assign s_axi_arready = arr_ff;
	assign s_axi_bvalid  = bv_ff;
	assign s_axi_bresp   = br_ff;
	assign s_axi_rvalid  = rv_ff;
	assign s_axi_rresp   = rr_ff;
	assign s_axi_rdata   = rd_ff;

	genvar gi;
	generate
		for (gi = 0; gi < dmc_pkg::NCH; gi++) begin : g_irq
			assign irq_req[gi] = ch_ff[gi].flag;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_ch   = ch_ff;
		nxt_st   = st_ff;
		nxt_cur  = cur_ff;
		nxt_mem  = mem_ff;
		nxt_prev = periph_req;
		nxt_awh  = awh_ff;
		nxt_wh   = wh_ff;
		nxt_awa  = awa_ff;
		nxt_wd   = wd_ff;
		nxt_ws   = ws_ff;
		nxt_bv   = bv_ff;
		nxt_br   = br_ff;
		nxt_rv   = rv_ff;
		nxt_rr   = rr_ff;
		nxt_rd   = rd_ff;
		swreq    = '0;
		found    = 1'b0;
		wv       = 32'h0;
		dw       = dec(awa_ff);
		dr       = dec(s_axi_araddr);

		// The engine runs first so that a write or a new request in the
		// same cycle overrides its update, except a flag it sets, which an IC write keeps.
		case (st_ff)
			dmc_pkg::ST_IDLE: begin
				for (int i = dmc_pkg::NCH - 1; i >= 0; i--) begin
					if (ch_ff[i].pend && ch_ff[i].mode[dmc_pkg::MD_EN] &&
						ch_ff[i].cnt != '0) begin
						found   = 1'b1;
						nxt_cur = 2'(i);
					end
				end
				if (found) begin
					nxt_ch[nxt_cur].pend = 1'b0;
					nxt_mem.req = 1'b1;
					nxt_mem.we  = 1'b0;
					nxt_mem.addr = ch_ff[nxt_cur].mode[dmc_pkg::MD_DIR] ?
						ch_ff[nxt_cur].fix : ch_ff[nxt_cur].mem;
					nxt_st = dmc_pkg::ST_RD;
				end
			end
			dmc_pkg::ST_RD: begin
				if (mem_ack) begin
					nxt_mem.we    = 1'b1;
					nxt_mem.wdata = mem_rdata;
					nxt_mem.addr  = cur.mode[dmc_pkg::MD_DIR] ?
						cur.mem : cur.fix;
					nxt_st = dmc_pkg::ST_WR;
				end
			end
			dmc_pkg::ST_WR: begin
				if (mem_ack) begin
					nxt_mem.req = 1'b0;
					nxt_mem.we  = 1'b0;
					nxt_ch[cur_ff].cnt = cur.cnt - dmc_pkg::CNT_ONE;
					nxt_ch[cur_ff].mem = cur.mem + dmc_pkg::ADDR_STEP;
					if (cur.cnt == dmc_pkg::CNT_ONE) begin
						nxt_ch[cur_ff].flag = 1'b1;
						if (cur.mode[dmc_pkg::MD_RPT]) begin
							nxt_ch[cur_ff].cnt = cur.crl;
							nxt_ch[cur_ff].mem = cur.mrl;
						end
					end
					nxt_st = dmc_pkg::ST_IDLE;
				end
			end
			default: nxt_st = dmc_pkg::ST_IDLE;
		endcase

		// Register writes wait for both address and data.
		if (s_axi_awvalid && awr_ff) begin
			nxt_awh = 1'b1;
			nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && wr_ff) begin
			nxt_wh = 1'b1;
			nxt_wd = s_axi_wdata;
			nxt_ws = s_axi_wstrb;
		end
		if (bv_ff && s_axi_bready)
			nxt_bv = 1'b0;
		if (awh_ff && wh_ff && !bv_ff) begin
			nxt_awh = 1'b0;
			nxt_wh  = 1'b0;
			nxt_bv  = 1'b1;
			nxt_br  = dw.hit ? dmc_pkg::RESP_OK : dmc_pkg::RESP_ERR;
			wv = merge(rd_reg(dw, ch_ff[dw.ch]), wd_ff, ws_ff);
			if (dw.hit) begin
				case (dw.kind)
					dmc_pkg::K_IC: begin
						nxt_ch[dw.ch].lvl = wv[2:0];
						// Software may only clear the flag.
						nxt_ch[dw.ch].flag = nxt_ch[dw.ch].flag &
							(wv[dmc_pkg::IC_FLAG] | ch_ff[dw.ch].flag !=
							nxt_ch[dw.ch].flag);
					end
					dmc_pkg::K_SL: begin
						nxt_ch[dw.ch].src = wv[4:0];
						swreq[dw.ch] = wv[dmc_pkg::SL_SW];
					end
					dmc_pkg::K_MODE: nxt_ch[dw.ch].mode = wv[2:0];
					dmc_pkg::K_FIX:  nxt_ch[dw.ch].fix  = wv[23:0];
					dmc_pkg::K_MEM:  nxt_ch[dw.ch].mem  = wv[23:0];
					dmc_pkg::K_MRL:  nxt_ch[dw.ch].mrl  = wv[23:0];
					dmc_pkg::K_CNT:  nxt_ch[dw.ch].cnt  = wv[15:0];
					default:         nxt_ch[dw.ch].crl  = wv[15:0];
				endcase
			end
		end

		if (rv_ff && s_axi_rready)
			nxt_rv = 1'b0;
		if (s_axi_arvalid && arr_ff) begin
			nxt_rv = 1'b1;
			nxt_rr = dr.hit ? dmc_pkg::RESP_OK : dmc_pkg::RESP_ERR;
			nxt_rd = dr.hit ? rd_reg(dr, ch_ff[dr.ch]) : 32'h0;
		end

		// A request edge sets pending last, so it beats the engine's clear.
		for (int i = 0; i < dmc_pkg::NCH; i++) begin
			if (((periph_req[ch_ff[i].src] && !prev_ff[ch_ff[i].src]) ||
				swreq[i]) && nxt_ch[i].mode[dmc_pkg::MD_EN] &&
				nxt_ch[i].cnt != '0)
				nxt_ch[i].pend = 1'b1;
		end

		nxt_awr = !nxt_awh && !nxt_bv;
		nxt_wr  = !nxt_wh && !nxt_bv;
		nxt_arr = !nxt_rv;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < dmc_pkg::NCH; i++)
				ch_ff[i] <= '0;
			st_ff   <= dmc_pkg::ST_IDLE;
			cur_ff  <= 2'h0;
			mem_ff  <= '0;
			{prev_ff, awa_ff, wd_ff, ws_ff, rd_ff} <= '0;
			{awh_ff, wh_ff, awr_ff, wr_ff, arr_ff} <= '0;
			{bv_ff, br_ff, rv_ff, rr_ff} <= '0;
		end else begin
			ch_ff   <= nxt_ch;
			st_ff   <= nxt_st;
			cur_ff  <= nxt_cur;
			mem_ff  <= nxt_mem;
			prev_ff <= nxt_prev;
			awh_ff  <= nxt_awh;
			wh_ff   <= nxt_wh;
			awa_ff  <= nxt_awa;
			wd_ff   <= nxt_wd;
			ws_ff   <= nxt_ws;
			awr_ff  <= nxt_awr;
			wr_ff   <= nxt_wr;
			arr_ff  <= nxt_arr;
			bv_ff   <= nxt_bv;
			br_ff   <= nxt_br;
			rv_ff   <= nxt_rv;
			rr_ff   <= nxt_rr;
			rd_ff   <= nxt_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_irq_last: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_WR && mem_ack && cur.cnt == 16'h0001
		|=> irq_req[$past(cur_ff)])
		else $error("flag not raised when count stepped to zero");
	a_cnt_step: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_WR && mem_ack && cur.cnt > 16'h0001
		&& !(awh_ff && wh_ff) |=> cur.cnt == $past(cur.cnt) - 16'h0001)
		else $error("count did not drop by one");
	a_rpt_reload: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_WR && mem_ack && cur.cnt == 16'h0001 &&
		cur.mode[1] && !(awh_ff && wh_ff) |=> cur.cnt == $past(cur.crl)
		&& cur.mem == $past(cur.mrl))
		else $error("repeat reload missed");
	a_mem_step: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_WR && mem_ack && cur.cnt > 16'h0001 &&
		!(awh_ff && wh_ff) |=> cur.mem == $past(cur.mem) + 24'h000001)
		else $error("memory pointer did not step");
	a_fix_side: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_WR && !cur.mode[0] && mem_cmd.req
		|-> mem_cmd.we && mem_cmd.addr == cur.fix)
		else $error("fixed side address wrong");
	a_rd_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff == dmc_pkg::ST_RD && mem_ack
		|=> mem_cmd.req && mem_cmd.we ##1 mem_cmd.req)
		else $error("write did not follow read");
	a_zero_skip: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(mem_cmd.req) |-> cur.cnt != 16'h0000 && cur.mode[2])
		else $error("transfer started on empty channel");
	a_src_edge: assert property (@(posedge aclk) disable iff (!aresetn)
		st_ff != dmc_pkg::ST_IDLE && ch_ff[2].mode[2] && cur_ff != 2'h2 &&
		ch_ff[2].cnt != 16'h0000 && !(awh_ff && wh_ff) &&
		periph_req[ch_ff[2].src] && !prev_ff[ch_ff[2].src]
		|=> ch_ff[2].pend)
		else $error("selected source edge lost");
	a_sw_req: assert property (@(posedge aclk) disable iff (!aresetn)
		awh_ff && wh_ff && !bv_ff && dw.hit && dw.kind == 3'h1 &&
		wv[5] && ch_ff[dw.ch].mode[2] && ch_ff[dw.ch].cnt != 16'h0000 &&
		cur_ff != dw.ch &&
		st_ff != dmc_pkg::ST_IDLE |=> ch_ff[$past(dw.ch)].pend)
		else $error("software request not pending");

endmodule // dmc_top

// [tb/dmc_mem_model.sv]
/*
 * Memory model for the controller's master port.
 * Assumes one held request at a time, each answered by a one-cycle ack
 * after wt idle cycles, and the same clock and reset as the controller.
 */
module dmc_mem_model (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire dmc_pkg::dmc_mem_t cmd,
	input  wire logic [7:0]        wt,
	output logic                   ack,
	output logic [15:0]            rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_ff;

	// The data bus toggles outside a read ack, so a stale sample cannot pass.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= 8'h00;
			ack <= 1'h0;
			rdata <= 16'h0000;
		end else begin
			rdata <= ~rdata;
			cnt_ff <= cmd.req ? cnt_ff + 8'h01 : 8'h00;
			ack <= 1'h0;
			if (ack)
				cnt_ff <= 8'h00;
			else if (cmd.req && cnt_ff >= wt) begin
				ack <= 1'h1;
				if (!cmd.we)
					rdata <= cmd.addr[15:0] ^ 16'h5A5A;
			end
		end
	end
endmodule // dmc_mem_model

// [tb/dmc_top_tb.sv]
/*
 * Self-checking bench for dmc_top: AXI4-Lite host tasks, a transfer log
 * and channel scenarios. Assumes dmc_mem_model on the memory port.
 */
module dmc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [13:0] IC0 = {dmc_pkg::IDX_IC0, 2'h0};
	localparam logic [13:0] IC1 = {dmc_pkg::IDX_IC1, 2'h0};
	logic              aclk = '0;
	logic              aresetn = '0;
	logic [13:0]       awaddr = '0;
	logic [13:0]       araddr = '0;
	logic              awvalid = '0;
	logic              wvalid = '0;
	logic              bready = '0;
	logic              arvalid = '0;
	logic              rready = '0;
	logic [31:0]       wdata = '0;
	logic [31:0]       periph_req = '0;
	logic [7:0]        wt = '0;
	logic              awready, wready, bvalid, arready, rvalid, mem_ack;
	logic [1:0]        bresp, rresp, br, rr;
	logic [31:0]       rdata, rv;
	logic [15:0]       mem_rdata;
	logic [3:0]        irq_req;
	dmc_pkg::dmc_mem_t mem_cmd;
	logic [23:0]       ra[$], wa[$];
	logic [15:0]       wd[$];
	int                miscompares = 0;
	int                n_compared = 0;

	dmc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .periph_req(periph_req), .mem_cmd(mem_cmd),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_req(irq_req));
	dmc_mem_model mem (.aclk(aclk), .aresetn(aresetn), .cmd(mem_cmd),
		.wt(wt), .ack(mem_ack), .rdata(mem_rdata));

	always #50 aclk = ~aclk;
	always @(posedge aclk)
		if (mem_cmd.req && mem_ack) begin
			if (mem_cmd.we) begin
				wa.push_back(mem_cmd.addr);
				wd.push_back(mem_cmd.wdata);
			end else
				ra.push_back(mem_cmd.addr);
		end
////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [13:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			t++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && t < 200);
		if (bvalid !== 1'h1)
			miscompares++;
		br = bresp;
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [13:0] a);
		int t;
		t = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			t++;
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && t < 200);
		if (rvalid !== 1'h1)
			miscompares++;
		rv = rdata;
		rr = rresp;
		rready <= 1'h0;
	endtask
	task automatic rchk(input logic [13:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask
	function automatic logic [13:0] cb(input int ch, input int k);
		return 14'h1000 + 14'(ch * 32 + k * 4);
	endfunction
	function automatic logic [13:0] sl(input int ch);
		return {dmc_pkg::IDX_SL0 + 12'(ch), 2'h0};
	endfunction
	task automatic prog(input int ch, input logic [31:0] md, fx, mm, ct);
		wr(cb(ch, 1), fx);
		wr(cb(ch, 2), mm);
		wr(cb(ch, 3), mm);
		wr(cb(ch, 4), ct);
		wr(cb(ch, 5), ct);
		wr(cb(ch, 0), md);
	endtask
	// Stalls are bounded here; the watchdog catches a hang.
	task automatic waitx(input int n);
		for (int t = 0; t < 400 && wa.size() < n; t++)
			@(posedge aclk);
		repeat (2) @(posedge aclk);
	endtask
	task automatic pulse(input int b);
		@(posedge aclk);
		periph_req[b] <= 1'h1;
		@(posedge aclk);
		periph_req[b] <= 1'h0;
	endtask
////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rchk(IC0, 0);
		rchk(cb(0, 4), 0);
		rd(14'h0000);
		chk(rr, dmc_pkg::RESP_ERR);
		wr(14'h0004, 32'hFF);
		chk(br, dmc_pkg::RESP_ERR);
		wr(sl(0), 32'hFF);
		chk(br, dmc_pkg::RESP_OK);
		rchk(sl(0), 32'h1F);
		chk(rr, dmc_pkg::RESP_OK);
		wr(IC0, 32'hF);
		rchk(IC0, 32'h7);
	endtask
	task automatic t_count;
		prog(0, 32'h4, 32'h40, 32'hFFFFF0, 32'h3);
		for (int i = 0; i < 4; i++) begin
			wr(sl(0), 32'h3F);
			waitx(i + 1);
			chk(irq_req[0], i >= 2);
		end
		chk(wa.size(), 3);
		for (int i = 0; i < 3; i++) begin
			chk(ra[i], 24'hFFFFF0 + i);
			chk(wa[i], 24'h40);
			chk(wd[i], (16'hFFF0 + i) ^ 16'h5A5A);
		end
		rchk(cb(0, 4), 0);
		rchk(cb(0, 2), 32'hFFFFF3);
		rchk(cb(0, 1), 32'h40);
		wr(IC0, 0);
		rchk(IC0, 0);
	endtask
	task automatic t_repeat;
		wa.delete();
		ra.delete();
		wd.delete();
		wr(sl(1), 32'h05);
		prog(1, 32'h7, 32'h200, 32'h100, 32'h2);
		wt <= 8'h03;
		pulse(6);
		repeat (20) @(posedge aclk);
		chk(wa.size(), 0);
		for (int i = 0; i < 3; i++) begin
			pulse(5);
			waitx(i + 1);
		end
		for (int i = 0; i < 3; i++) begin
			chk(ra[i], 24'h200);
			chk(wa[i], 24'h100 + (i == 1));
			chk(wd[i], 16'h0200 ^ 16'h5A5A);
		end
		rchk(cb(1, 4), 1);
		chk(irq_req[1], 1);
		wr(IC1, 0);
	endtask
	task automatic t_prio;
		wa.delete();
		wt <= 8'h1E;
		prog(2, 32'h4, 32'h300, 32'h310, 32'h1);
		prog(3, 32'h4, 32'h380, 32'h390, 32'h1);
		wr(sl(2), 32'h07);
		wr(sl(3), 32'h20);
		pulse(7);
		wr(sl(2), 32'h20);
		rchk(sl(2), 32'h80);
		waitx(2);
		chk(wa[0], 24'h380);
		chk(wa[1], 24'h300);
		chk(irq_req, 4'hC);
		rchk(sl(2), 0);
	endtask
////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		t_reset;
		t_count;
		t_repeat;
		t_prio;
		results;
	end
	initial begin
		#1000000;
		miscompares++;
		results;
	end
endmodule // dmc_top_tb
